/* File: bcfm_channel.sv */
// One channel of fault supervision, restart handling and current monitor sequencing.
`timescale 1ns/1ps
`default_nettype none
`include "bcfm_params.svh"
module bcfm_channel
  import bcfm_pkg::*;
#(
  parameter int FILT = `BCFM_FILT_CYCLES,
  parameter int MONC = `BCFM_MON_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fb_below_short,
  input  wire logic       fb_above_ov,
  input  wire logic       fb_below_ov_hys,
  input  wire logic       cs_above_oc_rise,
  input  wire logic       cs_below_oc_fall,
  input  wire logic       fb_above_ol,
  input  wire logic       cs_below_ol_ref,
  input  wire logic       ss_detect_enable,
  input  wire logic       ss_done,
  input  wire logic       mon_above,
  input  wire logic       mon_below,
  input  wire logic       ov_latch_en,
  input  wire logic       clear_latch,
  input  wire logic       mon_start,
  output logic            short_flag,
  output logic            ov_flag,
  output logic            oc_flag,
  output logic            ol_flag,
  output logic            gate_enable,
  output logic            soft_start_req,
  output logic            mon_done,
  output logic [1:0]      mon_result
);
  bcfm_state_t  st;
  bcfm_state_t  next_st;
  bcfm_mon_t    mst;
  logic [$clog2(MONC+1)-1:0] mcnt;
  logic         short_q;
  logic         ol_q;

  // Short and open-load qualifiers only look while soft-start permits detection.
  bcfm_filter #(.COUNT(FILT)) u_short (
    .pclk      (pclk),
    .presetn   (presetn),
    .cond      (fb_below_short & ss_detect_enable),
    .qualified (short_q)
  );
  bcfm_filter #(.COUNT(FILT)) u_ol (
    .pclk      (pclk),
    .presetn   (presetn),
    .cond      (fb_above_ol & cs_below_ol_ref & ss_detect_enable),
    .qualified (ol_q)
  );

  // Restart sequencing after a short: wait for it to clear, then soft-start again.
  always_comb begin
    next_st = st;
    case (st)
      BCFM_RUN:   if (short_q) next_st = BCFM_SHORT;
      BCFM_SHORT: if (!fb_below_short) next_st = BCFM_SOFT;
      BCFM_SOFT:  if (ss_done) next_st = BCFM_RUN;
      default:    next_st = BCFM_RUN;
    endcase
  end

  wire ov_release = ov_latch_en ? clear_latch : fb_below_ov_hys;

  // Flag registers; a fresh event wins over its release in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= BCFM_RUN;
      short_flag <= 1'b0;
      ov_flag    <= 1'b0;
      oc_flag    <= 1'b0;
      ol_flag    <= 1'b0;
    end else begin
      st <= next_st;
      if (short_q)
        short_flag <= 1'b1;
      else if (st == BCFM_SOFT && ss_done)
        short_flag <= 1'b0;
      if (fb_above_ov)
        ov_flag <= 1'b1;
      else if (ov_release)
        ov_flag <= 1'b0;
      if (cs_above_oc_rise)
        oc_flag <= 1'b1;
      else if (cs_below_oc_fall)
        oc_flag <= 1'b0;
      ol_flag <= ol_q;
    end
  end

  // Gate drive is registered; open load deliberately does not enter this term.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_enable    <= 1'b0;
      soft_start_req <= 1'b0;
    end else begin
      gate_enable    <= !(ov_flag | oc_flag | (next_st == BCFM_SHORT) | fb_above_ov
                          | cs_above_oc_rise);
      soft_start_req <= (next_st == BCFM_SOFT);
    end
  end

  // Current monitor: settle a fixed time then sample the window comparators.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst        <= BCFM_MON_IDLE;
      mcnt       <= '0;
      mon_done   <= 1'b0;
      mon_result <= 2'b00;
    end else begin
      case (mst)
        BCFM_MON_IDLE: if (mon_start) begin
          mst      <= BCFM_MON_WAIT;
          mcnt     <= '0;
          mon_done <= 1'b0;
        end
        BCFM_MON_WAIT: if (mcnt == ($clog2(MONC+1))'(MONC - 1)) begin
          mst        <= BCFM_MON_DONE;
          mon_done   <= 1'b1;
          mon_result <= {mon_above, mon_below};
        end else begin
          mcnt <= mcnt + 1'b1;
        end
        BCFM_MON_DONE: if (!mon_start) mst <= BCFM_MON_IDLE;
        default: mst <= BCFM_MON_IDLE;
      endcase
    end
  end

  property p_ov_gate;
    @(posedge pclk) disable iff (!presetn) ov_flag |=> !gate_enable;
  endproperty
  a_ov_gate: assert property (p_ov_gate) else $error("gate on during overvoltage");

  property p_oc_gate;
    @(posedge pclk) disable iff (!presetn) oc_flag |=> !gate_enable;
  endproperty
  a_oc_gate: assert property (p_oc_gate) else $error("gate on during overcurrent");

  property p_ov_latch;
    @(posedge pclk) disable iff (!presetn)
      (ov_flag && ov_latch_en && !clear_latch) |=> ov_flag;
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("latched overvoltage lost");

  property p_oc_release;
    @(posedge pclk) disable iff (!presetn)
      (oc_flag && cs_below_oc_fall && !cs_above_oc_rise) |=> !oc_flag;
  endproperty
  a_oc_release: assert property (p_oc_release) else $error("overcurrent not released");

  property p_ol_filter;
    @(posedge pclk) disable iff (!presetn)
      $rose(ol_flag) |-> $past(fb_above_ol & cs_below_ol_ref & ss_detect_enable, 2)
                         && $past(fb_above_ol & cs_below_ol_ref & ss_detect_enable, 9);
  endproperty
  a_ol_filter: assert property (p_ol_filter) else $error("open load set early");

  property p_ol_mask;
    @(posedge pclk) disable iff (!presetn) !ss_detect_enable [*8] |-> !ol_flag;
  endproperty
  a_ol_mask: assert property (p_ol_mask) else $error("open load while masked");

  property p_short_mask;
    @(posedge pclk) disable iff (!presetn)
      $rose(short_flag) |-> $past(ss_detect_enable, 2) && $past(ss_detect_enable, 9);
  endproperty
  a_short_mask: assert property (p_short_mask) else $error("short while masked");

  // Both ends of the eight-cycle qualifying run must have seen the low feedback.
  property p_short_filter;
    @(posedge pclk) disable iff (!presetn)
      $rose(short_flag) |-> $past(fb_below_short, 2) && $past(fb_below_short, 9);
  endproperty
  a_short_filter: assert property (p_short_filter) else $error("short set early");

  property p_mon_done;
    @(posedge pclk) disable iff (!presetn)
      (mst == BCFM_MON_IDLE && mon_start) |=> ##[1:64] mon_done;
  endproperty
  a_mon_done: assert property (p_mon_done) else $error("monitor never done");
endmodule
`default_nettype wire

/* File: bcfm_params.svh */
// Constants for the buck channel fault monitor: offsets, fields, reset values and timing.
`ifndef BCFM_PARAMS_SVH
`define BCFM_PARAMS_SVH
`define BCFM_OFF_SETUP0     12'h000
`define BCFM_OFF_SETUP1     12'h004
`define BCFM_OFF_FAULT0     12'h008
`define BCFM_OFF_FAULT1     12'h00C
`define BCFM_OFF_MON0       12'h010
`define BCFM_OFF_MON1       12'h014
`define BCFM_OFF_CTRL       12'h018
`define BCFM_THR_RESET      4'h2
`define BCFM_THR_STEP_MV    45
`define BCFM_FILT_CYCLES    8
`define BCFM_MON_CYCLES     16
`define BCFM_SETUP_OVLAT    4
`define BCFM_FLT_SHORT      0
`define BCFM_FLT_OV         1
`define BCFM_FLT_OC         2
`define BCFM_FLT_OL         3
`define BCFM_MON_START      0
`define BCFM_MON_DONE       1
`define BCFM_MON_RES_LO     2
`define BCFM_CTRL_CLEAR_LATCHED_FAULTS    0
`endif

/* File: bcfm_pkg.sv */
// Types shared by the buck channel fault monitor.
package bcfm_pkg;
  typedef enum logic [1:0] {
    BCFM_RUN   = 2'b00,
    BCFM_SHORT = 2'b01,
    BCFM_SOFT  = 2'b10
  } bcfm_state_t;
  typedef enum logic [1:0] {
    BCFM_MON_IDLE = 2'b00,
    BCFM_MON_WAIT = 2'b01,
    BCFM_MON_DONE = 2'b10
  } bcfm_mon_t;
endpackage

/* File: bcfm_filter.sv */
// Consecutive-cycle qualification filter for a synchronised comparator condition.
`timescale 1ns/1ps
`default_nettype none
`include "bcfm_params.svh"
module bcfm_filter #(
  parameter int COUNT = `BCFM_FILT_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic cond,
  output logic      qualified
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt;
  wire          at_top = (cnt == W'(COUNT - 1));

  // Any break in the condition restarts the count, so a glitching input never qualifies.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= '0;
      qualified <= 1'b0;
    end else if (!cond) begin
      cnt       <= '0;
      qualified <= 1'b0;
    end else if (at_top) begin
      qualified <= 1'b1;
    end else begin
      cnt <= cnt + W'(1);
    end
  end
endmodule
`default_nettype wire

/* File: bcfm_top.sv */
// APB register front end and two channel instances of the buck channel fault monitor.
`timescale 1ns/1ps
`default_nettype none
`include "bcfm_params.svh"
// Function
// - Four-bit short threshold code per channel
// - 45 mV steps, code 2 default
// - Overvoltage threshold independent of threshold code
// - Short clearing restarts channel via soft-start
// - Overvoltage sets flag, gates high impedance
// - Non-latched overvoltage auto resumes after hysteresis
// - Latched overvoltage cleared only by host
// - Overcurrent sets flag, gates off
// - Overcurrent releases below falling threshold
// - Open load needs eight qualified cycles
// - Open load masked during soft-start rise
// - Open load flags without touching gates
// - Open load and overvoltage may coexist
// - Host starts monitor, device signals done
// - Monitor yields two-bit window result
// - Short needs eight consecutive low cycles
// - Short detection masked during soft-start rise
// - Short sets flag, stops output current
module bcfm_top
  import bcfm_pkg::*;
#(
  parameter int NCH  = 2,
  parameter int FILT = `BCFM_FILT_CYCLES,
  parameter int MONC = `BCFM_MON_CYCLES
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NCH-1:0]   fb_below_short,
  input  wire logic [NCH-1:0]   fb_above_ov,
  input  wire logic [NCH-1:0]   fb_below_ov_hys,
  input  wire logic [NCH-1:0]   cs_above_oc_rise,
  input  wire logic [NCH-1:0]   cs_below_oc_fall,
  input  wire logic [NCH-1:0]   fb_above_ol,
  input  wire logic [NCH-1:0]   cs_below_ol_ref,
  input  wire logic [NCH-1:0]   ss_detect_enable,
  input  wire logic [NCH-1:0]   ss_done,
  input  wire logic [NCH-1:0]   mon_above,
  input  wire logic [NCH-1:0]   mon_below,
  output logic      [NCH*4-1:0] short_threshold_code,
  output logic      [NCH-1:0]   gate_enable,
  output logic      [NCH-1:0]   soft_start_req
);
  localparam int NIN = 11;

  // Comparator inputs come from analog blocks; two stages before any use.
  logic [NIN*NCH-1:0] sync1;
  logic [NIN*NCH-1:0] sync2;
  wire  [NIN*NCH-1:0] raw = {fb_below_short, fb_above_ov, fb_below_ov_hys,
                             cs_above_oc_rise, cs_below_oc_fall, fb_above_ol,
                             cs_below_ol_ref, ss_detect_enable, ss_done,
                             mon_above, mon_below};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // Slice helper: field f of channel c out of the packed synchronised bus.
  function automatic logic sbit(input logic [NIN*NCH-1:0] v, input int f, input int c);
    sbit = v[(NIN - 1 - f) * NCH + c];
  endfunction

  logic [4:0]       channel_setup_reg [NCH];
  logic [NCH-1:0]   clr_pulse;
  logic [NCH-1:0]   start_bit;
  logic [NCH-1:0]   short_f;
  logic [NCH-1:0]   ov_f;
  logic [NCH-1:0]   oc_f;
  logic [NCH-1:0]   ol_f;
  logic [NCH-1:0]   done_f;
  logic [1:0]       res_f [NCH];
  logic [NCH-1:0]   gate_w;
  logic [NCH-1:0]   ss_w;

  wire wr_xfer = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;

  // Address decode, one word per register; anything else answers with an error.
  wire hit_setup0 = (paddr == `BCFM_OFF_SETUP0);
  wire hit_setup1 = (paddr == `BCFM_OFF_SETUP1);
  wire hit_fault0 = (paddr == `BCFM_OFF_FAULT0);
  wire hit_fault1 = (paddr == `BCFM_OFF_FAULT1);
  wire hit_mon0   = (paddr == `BCFM_OFF_MON0);
  wire hit_mon1   = (paddr == `BCFM_OFF_MON1);
  wire hit_ctrl   = (paddr == `BCFM_OFF_CTRL);
  wire mapped     = hit_setup0 | hit_setup1 | hit_fault0 | hit_fault1 |
                    hit_mon0 | hit_mon1 | hit_ctrl;
  wire [NCH-1:0] hit_setup = {hit_setup1, hit_setup0};
  wire [NCH-1:0] hit_mon   = {hit_mon1, hit_mon0};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Setup and monitor-start registers; clear-latch is a one-cycle pulse.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          channel_setup_reg[g] <= {1'b0, `BCFM_THR_RESET};
          start_bit[g]         <= 1'b0;
          clr_pulse[g]         <= 1'b0;
        end else begin
          clr_pulse[g] <= wr_xfer & hit_ctrl & pstrb[0] & pwdata[`BCFM_CTRL_CLEAR_LATCHED_FAULTS];
          if (wr_xfer & hit_setup[g] & pstrb[0])
            channel_setup_reg[g] <= pwdata[4:0];
          if (wr_xfer & hit_mon[g] & pstrb[0])
            start_bit[g] <= pwdata[`BCFM_MON_START];
        end
      end
      assign short_threshold_code[g*4 +: 4] = channel_setup_reg[g][3:0];

      // Each channel owns its own supervisor instance.
      bcfm_channel #(.FILT(FILT), .MONC(MONC)) u_ch (
        .pclk             (pclk),
        .presetn          (presetn),
        .fb_below_short   (sbit(sync2, 0, g)),
        .fb_above_ov      (sbit(sync2, 1, g)),
        .fb_below_ov_hys  (sbit(sync2, 2, g)),
        .cs_above_oc_rise (sbit(sync2, 3, g)),
        .cs_below_oc_fall (sbit(sync2, 4, g)),
        .fb_above_ol      (sbit(sync2, 5, g)),
        .cs_below_ol_ref  (sbit(sync2, 6, g)),
        .ss_detect_enable (sbit(sync2, 7, g)),
        .ss_done          (sbit(sync2, 8, g)),
        .mon_above        (sbit(sync2, 9, g)),
        .mon_below        (sbit(sync2, 10, g)),
        .ov_latch_en      (channel_setup_reg[g][`BCFM_SETUP_OVLAT]),
        .clear_latch      (clr_pulse[g]),
        .mon_start        (start_bit[g]),
        .short_flag       (short_f[g]),
        .ov_flag          (ov_f[g]),
        .oc_flag          (oc_f[g]),
        .ol_flag          (ol_f[g]),
        .gate_enable      (gate_w[g]),
        .soft_start_req   (ss_w[g]),
        .mon_done         (done_f[g]),
        .mon_result       (res_f[g])
      );
    end
  endgenerate

  // Read multiplexer; reserved bits read zero.
  wire [31:0] rd_setup_w0 = {27'h000_0000, channel_setup_reg[0]};
  wire [31:0] rd_setup_w1 = {27'h000_0000, channel_setup_reg[1]};
  wire [31:0] rd_fault0 = {28'h000_0000, ol_f[0], oc_f[0], ov_f[0], short_f[0]};
  wire [31:0] rd_fault1 = {28'h000_0000, ol_f[1], oc_f[1], ov_f[1], short_f[1]};
  wire [31:0] rd_mon0   = {28'h000_0000, res_f[0], done_f[0], start_bit[0]};
  wire [31:0] rd_mon1   = {28'h000_0000, res_f[1], done_f[1], start_bit[1]};
  wire [31:0] rd_mux    = hit_setup0 ? rd_setup_w0 :
                          hit_setup1 ? rd_setup_w1 :
                          hit_fault0 ? rd_fault0 :
                          hit_fault1 ? rd_fault1 :
                          hit_mon0   ? rd_mon0 :
                          hit_mon1   ? rd_mon1 : 32'h0000_0000;

  // Zero-wait APB slave: read data is registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd_setup)
        prdata <= rd_mux;
    end
  end

  // Registered gate controls out of the channels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_enable    <= '0;
      soft_start_req <= '0;
    end else begin
      gate_enable    <= gate_w;
      soft_start_req <= ss_w;
    end
  end
endmodule
`default_nettype wire

/* File: bcfm_host_model.sv */
// Host-side APB master model that reaches the fault monitor registers.
`timescale 1ns/1ps
`default_nettype none
module bcfm_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // The bus idles released from time zero.
  initial begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 12'h000;
    pwdata  <= 32'h0000_0000;
    pstrb   <= 4'hf;
  end

  // One transfer: setup, access held until pready, then release and one idle edge.
  // Address and data flip on release so nobody can lean on stale values.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    pstrb   <= ~s;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: bcfm_tb_top.sv */
// Self-checking bench for the buck channel fault monitor.
`timescale 1ns/1ps
`default_nettype none
`include "bcfm_params.svh"
module bcfm_tb_top;
  typedef struct {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] exp;
    logic        err;
  } bcfm_row_t;
  localparam logic [11:0] F0 = `BCFM_OFF_FAULT0;
  localparam logic [11:0] F1 = `BCFM_OFF_FAULT1;
  localparam logic [31:0] B0 = 32'h0000_0001;
  localparam logic [31:0] B1 = 32'h0000_0002;
  localparam logic [31:0] B2 = 32'h0000_0004;
  localparam logic [31:0] B3 = 32'h0000_0008;
  localparam logic [31:0] NO = 32'h0000_0000;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [1:0]  fb_below_short, fb_above_ov, fb_below_ov_hys, cs_above_oc_rise;
  logic [1:0]  cs_below_oc_fall, fb_above_ol, cs_below_ol_ref, ss_detect_enable;
  logic [1:0]  ss_done, mon_above, mon_below, gate_enable, soft_start_req;
  logic [7:0]  short_threshold_code;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  bcfm_row_t   rows [11];

  always #4 pclk = ~pclk;

  bcfm_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
                          .pready, .pslverr);
  // The monitor count is shortened to keep the run brief.
  bcfm_top #(.MONC(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .fb_below_short, .fb_above_ov, .fb_below_ov_hys,
    .cs_above_oc_rise, .cs_below_oc_fall, .fb_above_ol, .cs_below_ol_ref, .ss_detect_enable,
    .ss_done, .mon_above, .mon_below, .short_threshold_code, .gate_enable, .soft_start_req);

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hf, q, e);
  endtask

  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, NO, 4'hf, q, e);
  endtask

  // Polls until the masked field matches, bounded so a stuck flag still fails.
  task automatic poll(input string nm, input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] ex);
    for (int i = 0; i < 40; i++) begin
      rd(a);
      if ((q & m) === ex) break;
    end
    chk(nm, ex, q & m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Gates are registered a cycle or two behind the flags, so settle first.
  task automatic gates(input logic [1:0] ex);
    cyc(3);
    chk("gate enable", {30'h0000_0000, ex}, {30'h0000_0000, gate_enable});
  endtask

  // Cuts a hung run short; the sequence needs only a few hundred cycles.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {fb_below_short, fb_above_ov, cs_above_oc_rise, fb_above_ol, cs_below_ol_ref} <= 10'h000;
    {ss_done, mon_above, mon_below} <= 6'h00;
    {fb_below_ov_hys, cs_below_oc_fall, ss_detect_enable} <= 6'h3f;
    rows = '{
      '{1'b0, `BCFM_OFF_SETUP0, NO, 32'h0000_0002, 1'b0},
      '{1'b0, `BCFM_OFF_SETUP1, NO, 32'h0000_0002, 1'b0},
      '{1'b0, F0, NO, NO, 1'b0},
      '{1'b0, `BCFM_OFF_MON1, NO, NO, 1'b0},
      '{1'b0, `BCFM_OFF_CTRL, NO, NO, 1'b0},
      '{1'b1, 12'h01c, B0, NO, 1'b1},
      '{1'b0, 12'h01c, NO, NO, 1'b1},
      '{1'b1, `BCFM_OFF_SETUP1, 32'h0000_000f, NO, 1'b0},
      '{1'b0, `BCFM_OFF_SETUP1, NO, 32'h0000_000f, 1'b0},
      '{1'b1, F0, 32'h0000_000f, NO, 1'b0},
      '{1'b0, F0, NO, NO, 1'b0}};
    cyc(12);
    chk("code in reset", 32'h0000_0022, {24'h00_0000, short_threshold_code});
    presetn <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      u_host.xfer(rows[i].wr, rows[i].a, rows[i].d, 4'hf, q, e);
      if (!rows[i].wr) begin
        chk("row read", rows[i].exp, q);
      end
      chk("row error", {31'h0000_0000, rows[i].err}, {31'h0000_0000, e});
    end
    gates(2'b11);
    for (int c = 0; c < 16; c++) begin
      wr(`BCFM_OFF_SETUP0, 32'(c));
      chk("code", {24'h00_0000, 4'hf, 4'(c)}, {24'h00_0000, short_threshold_code});
    end
    wr(`BCFM_OFF_SETUP0, 32'h0000_0002);
    // Short on channel 0: masked, too brief, then held and cleared.
    ss_detect_enable <= 2'b10;
    fb_below_short <= 2'b01;
    cyc(20);
    rd(F0);
    chk("short masked", NO, q & B0);
    fb_below_short <= 2'b00;
    ss_detect_enable <= 2'b11;
    cyc(2);
    fb_below_short <= 2'b01;
    cyc(7);
    fb_below_short <= 2'b00;
    cyc(15);
    rd(F0);
    chk("short seven", NO, q & B0);
    fb_below_short <= 2'b01;
    poll("short set", F0, B0, B0);
    gates(2'b10);
    rd(F1);
    chk("other channel", NO, q);
    fb_below_short <= 2'b00;
    cyc(6);
    chk("restart", 32'h0000_0001, {30'h0000_0000, soft_start_req});
    ss_done <= 2'b01;
    poll("short clear", F0, B0, NO);
    gates(2'b11);
    ss_done <= 2'b00;
    // Open load on channel 1, then overvoltage on top of it.
    ss_detect_enable <= 2'b01;
    fb_above_ol <= 2'b10;
    cs_below_ol_ref <= 2'b10;
    cyc(20);
    rd(F1);
    chk("open load masked", NO, q & B3);
    ss_detect_enable <= 2'b11;
    poll("open load", F1, B3, B3);
    gates(2'b11);
    fb_above_ov <= 2'b10;
    fb_below_ov_hys <= 2'b01;
    wr(`BCFM_OFF_SETUP1, NO);
    poll("ov set", F1, B1, B1);
    gates(2'b01);
    rd(F1);
    chk("ov with open load", 32'h0000_000a, q & 32'h0000_000f);
    {fb_above_ov, fb_above_ol, cs_below_ol_ref} <= 6'h00;
    cyc(5);
    rd(F1);
    chk("ov hysteresis", B1, q & B1);
    fb_below_ov_hys <= 2'b11;
    poll("ov auto clear", F1, B1 | B3, NO);
    gates(2'b11);
    // Latched overvoltage on channel 0 needs the clear pulse.
    wr(`BCFM_OFF_SETUP0, 32'h0000_0012);
    fb_above_ov <= 2'b01;
    fb_below_ov_hys <= 2'b10;
    poll("ov latched set", F0, B1, B1);
    fb_above_ov <= 2'b00;
    fb_below_ov_hys <= 2'b11;
    cyc(10);
    rd(F0);
    chk("ov held", B1, q & B1);
    gates(2'b10);
    wr(`BCFM_OFF_CTRL, B0);
    poll("ov cleared", F0, B1, NO);
    gates(2'b11);
    // Overcurrent on channel 1 with its own falling threshold.
    cs_above_oc_rise <= 2'b10;
    cs_below_oc_fall <= 2'b01;
    poll("oc set", F1, B2, B2);
    gates(2'b01);
    cs_above_oc_rise <= 2'b00;
    cyc(5);
    rd(F1);
    chk("oc held", B2, q & B2);
    cs_below_oc_fall <= 2'b11;
    poll("oc clear", F1, B2, NO);
    gates(2'b11);
    // Monitor window results: above, below, inside.
    for (int m = 0; m < 3; m++) begin
      mon_above <= {1'b0, m == 0};
      mon_below <= {1'b0, m == 1};
      wr(`BCFM_OFF_MON0, B0);
      poll("monitor done", `BCFM_OFF_MON0, B1, B1);
      chk("monitor result", 32'((m == 0) ? 8 : (m == 1) ? 4 : 0), q & 32'h0000_000c);
      wr(`BCFM_OFF_MON0, NO);
    end
    // A write whose low byte strobe is off must leave the register alone.
    u_host.xfer(1'b1, `BCFM_OFF_SETUP1, 32'h0000_0005, 4'h0, q, e);
    rd(`BCFM_OFF_SETUP1);
    chk("strobe off", NO, q);
    // Reset in mid-run returns registers and outputs to their idle values.
    presetn <= 1'b0;
    cyc(2);
    chk("gates in reset", NO, {30'h0000_0000, gate_enable});
    chk("code after reset", 32'h0000_0022, {24'h00_0000, short_threshold_code});
    presetn <= 1'b1;
    cyc(1);
    rd(`BCFM_OFF_SETUP0);
    chk("setup after reset", 32'h0000_0002, q);
    rd(`BCFM_OFF_MON0);
    chk("monitor after reset", NO, q);
    gates(2'b11);
    close_out();
  end
endmodule
`default_nettype wire
